/* File: core/can_filter_pkg.sv */
// Constants and carrier types for the CAN message-center filter block
package can_filter_pkg;

  // ---------------------------------------------------------------------------
  // Message centers and external-data window
  // ---------------------------------------------------------------------------
  localparam int           NUM_CENTERS      = 15;
  localparam logic [3:0]   RX_ONLY_CENTER   = 4'hf;
  localparam logic [7:0]   WINDOW_LOW_PAGE  = 8'h00;
  localparam logic [7:0]   WINDOW_HIGH_PAGE = 8'hff;
  localparam logic [7:0]   WINDOW_MID_PAGE  = 8'hdb;

  // Byte offsets inside a 16-byte center block (center n starts at n * 16)
  localparam logic [3:0]   OFS_ARB0         = 4'h2;
  localparam logic [3:0]   OFS_ARB1         = 4'h3;
  localparam logic [3:0]   OFS_ARB2         = 4'h4;
  localparam logic [3:0]   OFS_ARB3         = 4'h5;
  localparam logic [3:0]   OFS_FORMAT       = 4'h6;
  localparam logic [3:0]   OFS_DATA0        = 4'h7;
  localparam logic [3:0]   OFS_DATA7        = 4'he;

  // Receive-only center registers
  localparam logic [15:0]  MC15_ARBITRATION_BYTE0 = 16'hdbf2;
  localparam logic [15:0]  MC15_ARBITRATION_BYTE1 = 16'hdbf3;
  localparam logic [15:0]  MC15_ARBITRATION_BYTE2 = 16'hdbf4;
  localparam logic [15:0]  MC15_ARBITRATION_BYTE3 = 16'hdbf5;
  localparam logic [15:0]  MC15_FORMAT            = 16'hdbf6;
  localparam logic [15:0]  MC15_DATA_BYTES        = 16'hdbf7;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int           FMT_MEDIA_MASK_ENABLE = 0;
  localparam int           FMT_ID_MASK_ENABLE    = 1;
  localparam int           FMT_EXTENDED          = 2;
  localparam int           FMT_DIRECTION_TX      = 3;
  localparam int           FMT_BYTE_COUNT_LSB    = 4;
  localparam int           ARB3_OVERWRITE_ENABLE = 0;

  // Center control register bits
  localparam int           CTL_CENTER_READY      = 0;
  localparam int           CTL_TX_IRQ_ENABLE     = 1;
  localparam int           CTL_RX_IRQ_ENABLE     = 2;
  localparam int           CTL_REQUEST_FLAG      = 3;
  localparam int           CTL_DATA_UPDATED      = 4;
  localparam int           CTL_OVERRUN           = 5;
  localparam int           CTL_EXTERNAL_REQUEST  = 6;
  localparam int           CTL_TX_PENDING        = 7;
  localparam logic [7:0]   CTL_RESET             = 8'h00;

  localparam logic [28:0]  STD_ID_BITS           = 29'h1ffc0000;
  localparam logic [28:0]  EXT_ID_BITS           = 29'h1fffffff;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        ext;
    logic [28:0] id;
    logic [3:0]  dlc;
    logic [63:0] data;
  } frame_s;

  typedef struct packed {
    logic [10:0] std_mask;
    logic [28:0] ext_mask;
    logic [28:0] mc15_mask;
    logic [15:0] media_arb;
    logic [15:0] media_mask;
  } mask_bank_s;

  typedef struct packed {
    logic global_irq_enable;
    logic can_irq_enable;
    logic error_irq_enable;
    logic status_irq_enable;
    logic error_event;
    logic status_event;
  } irq_ctrl_s;

endpackage

/* File: core/can_msg_filter.sv */
// Acceptance filter, message-center storage and interrupt merge for the CAN controller
// Summary of operation
// - One interrupt line serves all fifteen centers plus error conditions.
// - Enabled transmit or receive success sets that center's request flag.
// - Hardware never clears a request flag; only software writes do.
// - Request flags are ORed, gated by global and CAN interrupt enables.
// - Error and status interrupts have own enables plus both global gates.
// - Acceptance testing begins only for frames free of bit errors.
// - Ready centers tested in ascending order; first passing center wins.
// - A frame is stored only when every enabled test passes.
// - Compare 11 identifier bits in standard format, 29 in extended.
// - Mask enable off means exact match; on compares only global mask ones.
// - Media enable compares first two data bytes under the media mask.
// - Center 15 with mask enable ANDs its own mask with the global mask.
// - Format byte holds direction and a four-bit byte count 0 to 8.
// - Center 15 only receives; its direction bit always reads zero.
// - After lost arbitration or error, reload lowest-numbered pending transmit.
// - Centers use 16-byte blocks; center 15 uses F2h-F5h, F6h, F7h-FEh.
// - Window upper address byte is 00 or FF per window select.
// - Unread receive center drops new frame unless overwrite set, then flags overrun.
// - Center 15 buffers a second frame, moving it in once flags clear.
module can_msg_filter (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        window_high_select,
  input  wire logic [23:0]                 mem_addr,
  input  wire logic                        mem_wr,
  input  wire logic                        mem_rd,
  input  wire logic [7:0]                  mem_wdata,
  output logic      [7:0]                  mem_rdata_q,
  input  wire logic [3:0]                  ctrl_sel,
  input  wire logic                        ctrl_wr,
  input  wire logic                        ctrl_rd,
  input  wire logic [7:0]                  ctrl_wdata,
  output logic      [7:0]                  ctrl_rdata_q,
  input  wire logic                        frame_valid,
  input  wire logic                        frame_error_free,
  input  wire can_filter_pkg::frame_s      frame,
  input  wire can_filter_pkg::mask_bank_s  masks,
  input  wire logic                        tx_done,
  input  wire logic [3:0]                  tx_done_center,
  input  wire logic                        tx_retry,
  output logic      [3:0]                  tx_reload_center_q,
  input  wire can_filter_pkg::irq_ctrl_s   irq_ctrl,
  output logic                             can_irq_q
);
  import can_filter_pkg::*;

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [7:0]  mem_q [0:255];
  logic [7:0]  ctrl_q [1:NUM_CENTERS];
  logic        buf_full_q;
  logic [63:0] buf_data_q;
  logic [3:0]  buf_dlc_q;

  // ---------------------------------------------------------------------------
  // External-data window decode
  // ---------------------------------------------------------------------------
  wire [7:0] page_sel   = window_high_select ? WINDOW_HIGH_PAGE : WINDOW_LOW_PAGE;
  wire [7:0] lo         = mem_addr[7:0];
  wire       in_window  = (mem_addr[23:16] == page_sel) && (mem_addr[15:8] == WINDOW_MID_PAGE);
  wire       mapped     = in_window && (lo[7:4] != 4'h0)
                          && (lo[3:0] >= OFS_ARB0) && (lo[3:0] <= OFS_DATA7);
  wire       cpu_we     = mem_wr && mapped;
  wire       fmt15_wr   = (lo[7:4] == RX_ONLY_CENTER) && (lo[3:0] == OFS_FORMAT);
  wire [7:0] cpu_wval   = fmt15_wr ? (mem_wdata & ~(8'h01 << FMT_DIRECTION_TX))
                                   : mem_wdata;

  // ---------------------------------------------------------------------------
  // Per-center acceptance tests
  // ---------------------------------------------------------------------------
  logic [NUM_CENTERS:1] match;
  logic [NUM_CENTERS:1] tx_pend;

  genvar gi;
  generate
    for (gi = 1; gi <= NUM_CENTERS; gi++)
    begin : g_center
      localparam int B = gi * 16;
      wire [7:0]  fmt      = mem_q[B + int'(OFS_FORMAT)];
      wire [28:0] arb      = {mem_q[B + int'(OFS_ARB0)], mem_q[B + int'(OFS_ARB1)],
                              mem_q[B + int'(OFS_ARB2)], mem_q[B + int'(OFS_ARB3)][7:3]};
      wire        ext      = fmt[FMT_EXTENDED];
      wire [28:0] id_bits  = ext ? EXT_ID_BITS : STD_ID_BITS;
      wire [28:0] gmask    = ext ? masks.ext_mask : {masks.std_mask, 18'h00000};
      wire [28:0] cmask    = (gi == NUM_CENTERS) ? (gmask & masks.mc15_mask) : gmask;
      wire [28:0] sel_mask = fmt[FMT_ID_MASK_ENABLE] ? (id_bits & cmask) : id_bits;
      wire        id_ok    = ((frame.id ^ arb) & sel_mask) == 29'h0;
      wire        media_ok = !fmt[FMT_MEDIA_MASK_ENABLE]
                             || (((frame.data[63:48] ^ masks.media_arb)
                                  & masks.media_mask) == 16'h0000);
      wire        is_rx    = !fmt[FMT_DIRECTION_TX];
      assign match[gi]   = ctrl_q[gi][CTL_CENTER_READY] && is_rx && (frame.ext == ext)
                           && id_ok && media_ok;
      assign tx_pend[gi] = ctrl_q[gi][CTL_TX_PENDING] && !is_rx;
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Priority search
  // ---------------------------------------------------------------------------
  logic [3:0] hit_idx;
  logic [3:0] pend_idx;

  always_comb
  begin
    hit_idx  = 4'h0;
    pend_idx = 4'h0;
    for (int k = NUM_CENTERS; k >= 1; k--)
    begin
      if (match[k])
        hit_idx = 4'(k);
      if (tx_pend[k])
        pend_idx = 4'(k);
    end
  end

  // ---------------------------------------------------------------------------
  // Frame disposition
  // ---------------------------------------------------------------------------
  wire        accept     = frame_valid && frame_error_free && (hit_idx != 4'h0);
  wire [7:0]  hit_ctl    = (hit_idx != 4'h0) ? ctrl_q[hit_idx] : CTL_RESET;
  wire [7:0]  hit_arb3   = mem_q[{hit_idx, OFS_ARB3}];
  wire        overwrite  = hit_arb3[ARB3_OVERWRITE_ENABLE];
  wire        hit15      = hit_idx == RX_ONLY_CENTER;
  wire [7:0]  ctl15      = ctrl_q[NUM_CENTERS];
  wire        buf_move   = buf_full_q && !ctl15[CTL_DATA_UPDATED] && !ctl15[CTL_REQUEST_FLAG]
                           && !ctl15[CTL_EXTERNAL_REQUEST];
  wire        unread     = hit_ctl[CTL_DATA_UPDATED] || (hit15 && buf_full_q);
  wire        rx_vis     = accept && (hit15 ? !unread : (!unread || overwrite));
  wire        rx_buf     = accept && hit15 && unread
                           && (!buf_full_q || buf_move || overwrite);
  wire        ovr_set    = accept && unread && overwrite
                           && (!hit15 || (buf_full_q && !buf_move));
  wire        vis_we     = rx_vis || buf_move;
  wire [3:0]  vis_idx    = buf_move ? RX_ONLY_CENTER : hit_idx;
  wire [63:0] vis_data   = buf_move ? buf_data_q : frame.data;
  wire [3:0]  vis_dlc    = buf_move ? buf_dlc_q : frame.dlc;

  // ---------------------------------------------------------------------------
  // Message memory
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (cpu_we)
      mem_q[lo] <= cpu_wval;
    if (vis_we)
    begin
      for (int k = 0; k < 8; k++)
        mem_q[{vis_idx, OFS_DATA0} + 8'(k)] <= vis_data[63 - 8 * k -: 8];
      mem_q[{vis_idx, OFS_FORMAT}] <= {vis_dlc, mem_q[{vis_idx, OFS_FORMAT}][3:0]};
    end
  end

  // Second-frame holding buffer of the receive-only center
  always_ff @(posedge clk)
  begin
    if (reset)
      buf_full_q <= 1'b0;
    else
      buf_full_q <= rx_buf || (buf_full_q && !buf_move);
  end

  always_ff @(posedge clk)
  begin
    if (rx_buf)
    begin
      buf_data_q <= frame.data;
      buf_dlc_q  <= frame.dlc;
    end
  end

  // ---------------------------------------------------------------------------
  // Center control registers
  // ---------------------------------------------------------------------------
  generate
    for (gi = 1; gi <= NUM_CENTERS; gi++)
    begin : g_ctl
      wire [7:0] cpu_val = (ctrl_wr && ctrl_sel == 4'(gi)) ? ctrl_wdata : ctrl_q[gi];
      wire       du_set  = vis_we && (vis_idx == 4'(gi));
      wire       tx_hit  = tx_done && (tx_done_center == 4'(gi));
      wire       req_set = (du_set && ctrl_q[gi][CTL_RX_IRQ_ENABLE])
                           || (tx_hit && ctrl_q[gi][CTL_TX_IRQ_ENABLE]);
      wire       ov_set  = ovr_set && (hit_idx == 4'(gi));
      wire [7:0] sets    = (8'(du_set) << CTL_DATA_UPDATED) | (8'(req_set) << CTL_REQUEST_FLAG)
                           | (8'(ov_set) << CTL_OVERRUN);
      wire [7:0] clrs    = (gi == NUM_CENTERS || tx_hit) ? (8'h01 << CTL_TX_PENDING) : 8'h00;
      always_ff @(posedge clk)
      begin
        if (reset)
          ctrl_q[gi] <= CTL_RESET;
        else
          ctrl_q[gi] <= (cpu_val & ~clrs) | sets;
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Read ports
  // ---------------------------------------------------------------------------
  wire [7:0] mem_rval  = mapped ? mem_q[lo] : 8'h00;
  wire [7:0] ctrl_rval = (ctrl_sel != 4'h0) ? ctrl_q[ctrl_sel] : 8'h00;

  always_ff @(posedge clk)
  begin
    if (reset)
      mem_rdata_q <= 8'h00;
    else if (mem_rd)
      mem_rdata_q <= mem_rval;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl_rdata_q <= 8'h00;
    else if (ctrl_rd)
      ctrl_rdata_q <= ctrl_rval;
  end

  // ---------------------------------------------------------------------------
  // Transmit reload and interrupt
  // ---------------------------------------------------------------------------
  logic [NUM_CENTERS:1] req_vec;

  generate
    for (gi = 1; gi <= NUM_CENTERS; gi++)
    begin : g_req
      assign req_vec[gi] = ctrl_q[gi][CTL_REQUEST_FLAG];
    end
  endgenerate

  wire irq_src = (|req_vec)
                 || (irq_ctrl.error_irq_enable && irq_ctrl.error_event)
                 || (irq_ctrl.status_irq_enable && irq_ctrl.status_event);
  wire irq_d   = irq_ctrl.global_irq_enable && irq_ctrl.can_irq_enable && irq_src;

  always_ff @(posedge clk)
  begin
    if (reset)
      tx_reload_center_q <= 4'h0;
    else if (tx_retry)
      tx_reload_center_q <= pend_idx;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      can_irq_q <= 1'b0;
    else
      can_irq_q <= irq_d;
  end

endmodule

/* File: dv/can_msg_filter_chk.sv */
// Port-level property checker for the CAN message-center filter
module can_msg_filter_chk
  import can_filter_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      reset,
  input wire logic                      window_high_select,
  input wire logic [23:0]               mem_addr,
  input wire logic                      mem_rd,
  input wire logic [7:0]                mem_rdata_q,
  input wire logic [3:0]                ctrl_sel,
  input wire logic                      ctrl_rd,
  input wire logic [7:0]                ctrl_rdata_q,
  input wire logic                      tx_retry,
  input wire logic [3:0]                tx_reload_center_q,
  input wire can_filter_pkg::irq_ctrl_s irq_ctrl,
  input wire logic                      can_irq_q
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);

  wire gate = irq_ctrl.global_irq_enable && irq_ctrl.can_irq_enable;

  irq_source_a: assert property ($rose(can_irq_q) |-> $past(gate))
    else $error("interrupt rose without both enables");
  irq_off_a: assert property (!gate |=> !can_irq_q)
    else $error("interrupt high with an enable clear");
  err_irq_a: assert property (gate && irq_ctrl.error_irq_enable && irq_ctrl.error_event
    |=> can_irq_q) else $error("enabled error condition gave no interrupt");
  stat_irq_a: assert property (gate && irq_ctrl.status_irq_enable && irq_ctrl.status_event
    |=> can_irq_q) else $error("enabled status condition gave no interrupt");
  window_page_a: assert property (mem_rd && mem_addr[23:16] !=
    (window_high_select ? WINDOW_HIGH_PAGE : WINDOW_LOW_PAGE) |=> mem_rdata_q == 8'h00)
    else $error("read outside the selected window page returned data");
  mem_hold_a: assert property (!mem_rd |=> $stable(mem_rdata_q))
    else $error("memory read data changed without a read");
  ctl_hold_a: assert property (!ctrl_rd |=> $stable(ctrl_rdata_q))
    else $error("control read data changed without a read");
  ctl_unmapped_a: assert property (ctrl_rd && ctrl_sel == 4'h0 |=> ctrl_rdata_q == 8'h00)
    else $error("unmapped control read returned data");
  reload_hold_a: assert property (!tx_retry |=> $stable(tx_reload_center_q))
    else $error("reload center changed without a retry");
  reload_rx_a: assert property (tx_retry |=> tx_reload_center_q != RX_ONLY_CENTER)
    else $error("receive-only center chosen for transmit");
endmodule

/* File: dv/can_node_model.sv */
// Remote CAN node model handing finished frames to the filter
module can_node_model
  import can_filter_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   send,
  input  wire logic                   error_free,
  input  wire can_filter_pkg::frame_s frame_in,
  output logic                        frame_valid,
  output logic                        frame_error_free,
  output can_filter_pkg::frame_s      frame
);
  timeunit 1ns;
  timeprecision 1ns;
  // Between frames the frame and error-free lines carry the inverse of their last value, never a stale copy
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      frame_valid      <= 1'b0;
      frame_error_free <= 1'b0;
      frame            <= '0;
    end
    else
    begin
      frame_valid      <= send;
      frame_error_free <= send ? error_free : !frame_error_free;
      frame            <= send ? frame_in : ~frame;
    end
  end
endmodule

/* File: dv/test_can_msg_filter.sv */
// Self-checking bench for the CAN message-center filter
module test_can_msg_filter;
  import can_filter_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, reset = 1, whs = 0, mwr = 0, mrd = 0, cwr = 0, crd = 0;
  logic       txd = 0, txr = 0, snd = 0, ok = 0, fv, fe, irq;
  logic [7:0] pg = 8'h00, lo = 8'h00, wd = 8'h00, mrq, crq;
  logic [3:0] sel = 4'h0, txc = 4'h0, rld;
  frame_s     fr = '0, fo;
  mask_bank_s mk = '{11'h7ff, 29'h1ffffff0, 29'h1ffffeff, 16'h1234, 16'hff00};
  irq_ctrl_s  ic = 6'b110000;
  int         fails = 0, compares = 0, cyc = 0;

  always #25 clk = ~clk;

  can_msg_filter dut_u (.clk(clk), .reset(reset), .window_high_select(whs),
    .mem_addr({pg, WINDOW_MID_PAGE, lo}), .mem_wr(mwr), .mem_rd(mrd), .mem_wdata(wd),
    .mem_rdata_q(mrq), .ctrl_sel(sel), .ctrl_wr(cwr), .ctrl_rd(crd), .ctrl_wdata(wd),
    .ctrl_rdata_q(crq), .frame_valid(fv), .frame_error_free(fe), .frame(fo), .masks(mk),
    .tx_done(txd), .tx_done_center(txc), .tx_retry(txr), .tx_reload_center_q(rld),
    .irq_ctrl(ic), .can_irq_q(irq));
  can_node_model node_u (.clk(clk), .reset(reset), .send(snd), .error_free(ok),
    .frame_in(fr), .frame_valid(fv), .frame_error_free(fe), .frame(fo));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One byte access: ctl picks the control port, rd compares the read data with d
  task automatic acc(input bit ctl, input bit rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    lo <= a;
    sel <= a[3:0];
    wd <= d;
    {cwr, crd, mwr, mrd} <= {ctl & !rd, ctl & rd, !ctl & !rd, !ctl & rd};
    @(posedge clk);
    {cwr, crd, mwr, mrd} <= 4'h0;
    #1;
    if (rd)
      chk(ctl ? "ctrl" : "mem", ctl ? crq : mrq, d);
  endtask

  task automatic setc(input logic [3:0] n, input logic [28:0] id, input logic [7:0] f);
    acc(0, 0, {n, 4'h2}, id[28:21]);
    acc(0, 0, {n, 4'h3}, id[20:13]);
    acc(0, 0, {n, 4'h4}, id[12:5]);
    acc(0, 0, {n, 4'h5}, {id[4:0], 3'b000});
    acc(0, 0, {n, 4'h6}, f);
    acc(1, 0, {4'h0, n}, 8'h05);
  endtask

  task automatic send(input logic [28:0] id, input logic [15:0] d01, input bit good);
    @(posedge clk);
    fr <= '{1'b1, id, 4'h8, {d01, 48'h0}};
    ok <= good;
    snd <= 1'b1;
    @(posedge clk);
    snd <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic tx(input bit done, input logic [3:0] c);
    @(posedge clk);
    {txd, txr, txc} <= {done, !done, c};
    @(posedge clk);
    {txd, txr} <= 2'b00;
    repeat (2) @(posedge clk);
  endtask

  task automatic report_and_stop();
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (int n = 0; n < 16; n++)
      acc(1, 1, 8'(n), CTL_RESET);
    acc(0, 0, 8'hf6, 8'hff);
    acc(0, 1, 8'hf6, 8'hf7);
    acc(0, 0, 8'hf7, 8'ha5);
    @(posedge clk);
    pg <= WINDOW_HIGH_PAGE;
    acc(0, 1, 8'hf7, 8'h00);
    @(posedge clk);
    whs <= 1'b1;
    acc(0, 1, 8'hf7, 8'ha5);
    @(posedge clk);
    {pg, whs} <= 9'h0;
    setc(4'h2, 29'h0abcdef1, 8'h04);
    setc(4'h3, 29'h0abcdef1, 8'h04);
    setc(4'h4, 29'h1234567f, 8'h06);
    setc(4'hf, 29'h07654321, 8'h07);
    send(29'h0abcdef1, 16'h1234, 1'b0);
    acc(1, 1, 8'h02, 8'h05);
    chk("irq", irq, 1'b0);
    send(29'h0abcdef1, 16'h5a5a, 1'b1);
    acc(1, 1, 8'h02, 8'h1d);
    acc(1, 1, 8'h03, 8'h05);
    acc(0, 1, 8'h27, 8'h5a);
    acc(0, 1, 8'h26, 8'h84);
    chk("irq", irq, 1'b1);
    send(29'h0abcdef1, 16'h6b6b, 1'b1);
    acc(0, 1, 8'h27, 8'h5a);
    acc(0, 0, 8'h25, 8'h89);
    send(29'h0abcdef1, 16'h6b6b, 1'b1);
    acc(0, 1, 8'h27, 8'h6b);
    acc(1, 1, 8'h02, 8'h3d);
    send(29'h1234566f, 16'h0000, 1'b1);
    acc(1, 1, 8'h04, 8'h05);
    send(29'h1234567c, 16'h0000, 1'b1);
    acc(1, 1, 8'h04, 8'h1d);
    send(29'h07654221, 16'h13ab, 1'b1);
    acc(1, 1, 8'h0f, 8'h05);
    send(29'h07654221, 16'h12ab, 1'b1);
    acc(1, 1, 8'h0f, 8'h1d);
    send(29'h07654321, 16'h12cd, 1'b1);
    acc(0, 1, 8'hf8, 8'hab);
    acc(1, 0, 8'h0f, 8'h05);
    acc(0, 1, 8'hf8, 8'hcd);
    acc(1, 1, 8'h02, 8'h3d);
    for (int n = 2; n < 16; n++)
      acc(1, 0, 8'(n), 8'h05);
    repeat (3) @(posedge clk);
    chk("irq", irq, 1'b0);
    ic <= 6'b111110;
    repeat (3) @(posedge clk);
    chk("irq", irq, 1'b1);
    ic <= 6'b011101;
    repeat (3) @(posedge clk);
    chk("irq", irq, 1'b0);
    ic <= 6'b110101;
    repeat (3) @(posedge clk);
    chk("irq", irq, 1'b1);
    ic <= 6'b110000;
    acc(0, 0, 8'h56, 8'h08);
    acc(0, 0, 8'h76, 8'h08);
    acc(1, 0, 8'h05, 8'h83);
    acc(1, 0, 8'h07, 8'h81);
    tx(1'b0, 4'h0);
    chk("reload", rld, 4'h5);
    tx(1'b1, 4'h5);
    acc(1, 1, 8'h05, 8'h0b);
    tx(1'b0, 4'h0);
    chk("reload", rld, 4'h7);
    report_and_stop();
  end
endmodule

bind can_msg_filter can_msg_filter_chk chk_u (.clk(clk), .reset(reset),
  .window_high_select(window_high_select), .mem_addr(mem_addr), .mem_rd(mem_rd),
  .mem_rdata_q(mem_rdata_q), .ctrl_sel(ctrl_sel), .ctrl_rd(ctrl_rd),
  .ctrl_rdata_q(ctrl_rdata_q), .tx_retry(tx_retry), .tx_reload_center_q(tx_reload_center_q),
  .irq_ctrl(irq_ctrl), .can_irq_q(can_irq_q));
